// file: core/edc_regs.sv
// Purpose: Energy_efficiency_control and variant capability registers behind AXI4-Lite.
// Assumes: Status inputs come from the PHY core on another timebase.
// Notes:   Page select must hold page 2 to reach the two registers.

module edc_regs #(
   parameter logic       IND_GRADE = 1'b0,
   parameter logic       QUAD_DEV  = 1'b1,
   parameter logic       PTP_CAP   = 1'b1,
   parameter logic       SEC_CAP   = 1'b1,
   parameter logic       DUAL_MED  = 1'b1,
   parameter logic       PTP_HP    = 1'b1,
   parameter logic       KEY_256   = 1'b1,
   // Variant number, value arbitrary
   parameter logic [7:0] DASH_BCD  = 8'h42
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      port_soft_rst,
   // AXI4-Lite slave
   input  wire logic [edc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [edc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // PHY core status, asynchronous
   input  wire logic                      link_up,
   input  wire logic                      eee_1000_on,
   input  wire logic                      eee_100_on,
   // PHY core, same clock
   input  wire logic [1:0]                link_speed,
   input  wire logic [1:0]                speed_sel,
   input  wire logic [3:0]                led_state,
   input  wire logic                      mac_tx_lpi,
   input  wire logic                      mdi_rx_lpi,
   // Controls toward the PHY core
   output logic                           lp10_mode_en,
   output logic                           led_fiber_uni_en,
   output logic [3:0]                     led_out_n,
   output logic                           force_1000_link,
   output logic                           internal_packet_generator_lpi,
   output logic                           mdi_tx_lpi,
   output logic                           mac_rx_lpi,
   output logic [edc_pkg::PAGE_W-1:0]     page_sel
);
   import edc_pkg::*;

   // BCD check on the variant number, refused at elaboration
   // A nibble above 9 would read back as a dash number no part can carry
   if (DASH_BCD[7:4] > 4'h9 || DASH_BCD[3:0] > 4'h9) begin : g_bcd_chk
      $error("DASH_BCD is not two BCD digits");
   end

   // Target decode shared by read and write paths
   // Paging remaps only indices 16 and up; page select answers on any page
   function automatic edc_tgt_t decode(input logic [5:0] idx,
                                       input logic [15:0] page);
      edc_tgt_t t;
      t = TGT_NONE;
      if (idx == IDX_PAGE) begin
         t = TGT_PAGE;
      end else if (idx >= IDX_EXT_LO && page == PAGE_TWO) begin
         if (idx == IDX_CTRL) begin
            t = TGT_CTRL;
         end else if (idx == IDX_CAP) begin
            t = TGT_CAP;
         end
      end
      return t;
   endfunction

   // Strobe-masked update of a 16-bit word
   // Upper lanes carry nothing: the registers are 16 bits wide
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  st);
      logic [15:0] r;
      r = old;
      if (st[0]) begin
         r[7:0] = wd[7:0];
      end
      if (st[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   logic [2:0]  st_raw;
   logic [2:0]  st_s1_q;
   logic [2:0]  st_s2_q;
   logic [2:0]  st_s3_q;
   logic [2:0]  st_q;
   logic [15:0] ctrl_q;
   logic [15:0] page_q;
   logic [15:0] ctrl_rd;
   logic [15:0] cap_rd;
   logic [5:0]  aw_idx_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_got_q;
   logic        w_got_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   edc_st_t     rd_st_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   edc_tgt_t    w_tgt;
   edc_tgt_t    r_tgt;
   logic        do_write;
   logic        in_100;
   logic        in_1000;
   logic        tx_block;
   logic        rx_block;

   assign st_raw = {eee_100_on, eee_1000_on, link_up};

   // Three-stage synchronisers; change taken when stages 2 and 3 agree
   // Agreement guards against a value caught while it was changing
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               st_s1_q[g] <= 1'b0;
               st_s2_q[g] <= 1'b0;
               st_s3_q[g] <= 1'b0;
               st_q[g]    <= 1'b0;
            end else begin
               st_s1_q[g] <= st_raw[g];
               st_s2_q[g] <= st_s1_q[g];
               st_s3_q[g] <= st_s2_q[g];
               if (st_s2_q[g] == st_s3_q[g]) begin
                  st_q[g] <= st_s3_q[g];
               end
            end
         end
      end
   endgenerate

   // Write channel handshakes
   // Ready drops while a response waits, so one write at a time
   assign s_axi_awready = !aw_got_q && !bvalid_q;
   assign s_axi_wready  = !w_got_q && !bvalid_q;
   assign do_write      = aw_got_q && w_got_q && !bvalid_q;
   assign w_tgt         = decode(aw_idx_q, page_q);

   // Capture address and data in either order
   // Each channel is released as soon as it is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         aw_idx_q <= 6'h00;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[7:2];
         end else if (do_write) begin
            aw_got_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (do_write) begin
            w_got_q <= 1'b0;
         end
      end
   end

   // Write response
   // Refused index still answers, with a decode error
   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (w_tgt == TGT_NONE) ? RESP_DEC : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // Page select; port soft reset returns it to the main set
   // No stale extended page survives a soft reset of the port
   always_ff @(posedge clk) begin
      if (rst || port_soft_rst) begin
         page_q <= PAGE_MAIN;
      end else if (do_write && w_tgt == TGT_PAGE) begin
         page_q <= merge(page_q, wdata_q, wstrb_q);
      end
   end

   // Sticky controls: hardware reset only
   // Port soft reset left out on purpose so debug settings persist
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
      end else if (do_write && w_tgt == TGT_CTRL) begin
         // Status and reserved bits are not stored
         ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_WMASK;
      end
   end

   // Control word as read
   // Status bits come from the synchronised copies, never the raw pins
   always_comb begin
      ctrl_rd           = ctrl_q & CTRL_WMASK;
      ctrl_rd[B_LINK]   = st_q[0];
      ctrl_rd[B_EEE1G]  = st_q[1];
      ctrl_rd[B_EEE100] = st_q[2];
   end

   // Capability word; bit 11 reserved reads 0
   // Straps are parameters so each variant is a build option
   always_comb begin
      cap_rd           = 16'h0000;
      cap_rd[B_IND]    = IND_GRADE;
      cap_rd[B_QUAD]   = QUAD_DEV;
      cap_rd[B_PTP]    = PTP_CAP;
      cap_rd[B_SEC]    = SEC_CAP;
      cap_rd[B_DUAL]   = DUAL_MED;
      cap_rd[B_PTPHP]  = PTP_HP;
      cap_rd[B_K256]   = KEY_256;
      cap_rd[7:0]      = DASH_BCD;
   end

   // Read channel
   // Target chosen with the page value at address time
   assign r_tgt         = decode(s_axi_araddr[7:2], page_q);
   assign s_axi_arready = (rd_st_q == ST_IDLE);

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_st_q <= ST_IDLE;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else begin
         unique case (rd_st_q)
            ST_IDLE: begin
               if (s_axi_arvalid) begin
                  rd_st_q <= ST_RESP;
                  rresp_q <= RESP_OKAY;
                  unique case (r_tgt)
                     TGT_PAGE: rdata_q <= {16'h0000, page_q};
                     TGT_CTRL: rdata_q <= {16'h0000, ctrl_rd};
                     TGT_CAP:  rdata_q <= {16'h0000, cap_rd};
                     TGT_NONE: begin
                        rdata_q <= 32'h0000_0000;
                        rresp_q <= RESP_DEC;
                     end
                  endcase
               end
            end
            ST_RESP: begin
               if (s_axi_rready) begin
                  rd_st_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   assign s_axi_rvalid = (rd_st_q == ST_RESP);
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // Speed-dependent LPI gating
   // Inhibits act only at their own speed; 10 Mb/s passes LPI untouched
   assign in_100   = (link_speed == SPD_100);
   assign in_1000  = (link_speed == SPD_1000);
   assign tx_block = (in_100 && ctrl_q[B_IN100TX])
                  || (in_1000 && ctrl_q[B_IN1GTX]);
   assign rx_block = (in_100 && ctrl_q[B_IN100RX])
                  || (in_1000 && ctrl_q[B_IN1GRX]);

   // Registered controls toward the PHY core
   // One flop on each control keeps the PHY side free of decode glitches
   always_ff @(posedge clk) begin
      if (rst) begin
         lp10_mode_en                  <= 1'b0;
         led_fiber_uni_en              <= 1'b0;
         led_out_n                     <= 4'hF;
         force_1000_link               <= 1'b0;
         internal_packet_generator_lpi <= 1'b0;
         mdi_tx_lpi                    <= 1'b0;
         mac_rx_lpi                    <= 1'b0;
      end else begin
         lp10_mode_en     <= ctrl_q[B_LP10];
         led_fiber_uni_en <= ctrl_q[B_LEDFU];
         // Lit LED pulls low unless inverted
         led_out_n <= ~(led_state ^ ctrl_q[B_INV_HI:B_INV_LO]);
         force_1000_link <= ctrl_q[B_FORCE1G]
                            && (speed_sel == SEL_1000);
         internal_packet_generator_lpi <= ctrl_q[B_FTXLPI];
         // Forced LPI overrides MAC data; else pass MAC idles
         mdi_tx_lpi <= ctrl_q[B_FTXLPI]
                       || (mac_tx_lpi && !tx_block);
         mac_rx_lpi <= mdi_rx_lpi && !rx_block;
      end
   end

   assign page_sel = page_q;

endmodule

// file: inc/edc_pkg.sv
// Purpose: Constants for the EEE debug and capability register bank.
// Assumes: Register indices are word indices; byte address is 4x index.
// Notes:   Widths and reset values live here only.
package edc_pkg;
   localparam int          ADDR_W     = 8;
   localparam int          REG_W      = 16;
   localparam int          PAGE_W     = 16;
   // Register indices and page codes
   localparam logic [5:0]  IDX_CTRL   = 6'h11;
   localparam logic [5:0]  IDX_CAP    = 6'h12;
   localparam logic [5:0]  IDX_PAGE   = 6'h1F;
   localparam logic [5:0]  IDX_EXT_LO = 6'h10;
   localparam logic [15:0] PAGE_MAIN  = 16'h0000;
   localparam logic [15:0] PAGE_TWO   = 16'h0002;
   // Control register fields
   localparam int          B_LP10     = 15;
   localparam int          B_LEDFU    = 14;
   localparam int          B_INV_HI   = 13;
   localparam int          B_INV_LO   = 10;
   localparam int          B_LINK     = 8;
   localparam int          B_EEE1G    = 7;
   localparam int          B_EEE100   = 6;
   localparam int          B_FORCE1G  = 5;
   localparam int          B_FTXLPI   = 4;
   localparam int          B_IN100TX  = 3;
   localparam int          B_IN100RX  = 2;
   localparam int          B_IN1GTX   = 1;
   localparam int          B_IN1GRX   = 0;
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'hFC3F;
   // Capability register fields
   localparam int          B_IND      = 15;
   localparam int          B_QUAD     = 14;
   localparam int          B_PTP      = 13;
   localparam int          B_SEC      = 12;
   localparam int          B_DUAL     = 10;
   localparam int          B_PTPHP    = 9;
   localparam int          B_K256     = 8;
   // Speed codes and forced-gigabit selection
   localparam logic [1:0]  SPD_10     = 2'h0;
   localparam logic [1:0]  SPD_100    = 2'h1;
   localparam logic [1:0]  SPD_1000   = 2'h2;
   localparam logic [1:0]  SEL_1000   = 2'h2;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_DEC   = 2'h3;
   typedef enum logic [1:0] {
      TGT_NONE = 2'b00,
      TGT_PAGE = 2'b01,
      TGT_CTRL = 2'b10,
      TGT_CAP  = 2'b11
   } edc_tgt_t;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RESP = 1'b1
   } edc_st_t;
endpackage

// file: tb/edc_regs_checker.sv
// Purpose: Assertions on the register bank bus and PHY-side controls.
// Assumes: Sees the register bank ports only; one clock domain.
// Notes:   Bound into every register bank instance.
module edc_regs_checker
   import edc_pkg::*;
(
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic [edc_pkg::ADDR_W-1:0]  s_axi_araddr,
   input wire logic                        s_axi_arvalid,
   input wire logic                        s_axi_arready,
   input wire logic [31:0]                 s_axi_rdata,
   input wire logic [1:0]                  s_axi_rresp,
   input wire logic                        s_axi_rvalid,
   input wire logic                        s_axi_bvalid,
   input wire logic                        s_axi_bready,
   input wire logic [1:0]                  speed_sel,
   input wire logic                        force_1000_link,
   input wire logic                        internal_packet_generator_lpi,
   input wire logic                        mdi_tx_lpi,
   input wire logic                        mac_tx_lpi,
   input wire logic                        mac_rx_lpi,
   input wire logic                        mdi_rx_lpi
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Index of the read in flight
   logic [5:0] ar_idx_q;
   always_ff @(posedge clk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ar_idx_q <= s_axi_araddr[7:2];
      end
   end
   // Properties
   property p_force; force_1000_link |-> $past(speed_sel) == SEL_1000; endproperty
   property p_gen; internal_packet_generator_lpi |-> mdi_tx_lpi; endproperty
   property p_tx; mdi_tx_lpi && !internal_packet_generator_lpi |-> $past(mac_tx_lpi); endproperty
   property p_rx; mac_rx_lpi |-> $past(mdi_rx_lpi); endproperty
   property p_rlat; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
   property p_bone; s_axi_bvalid && s_axi_bready |-> ##1 !s_axi_bvalid; endproperty
   property p_dec; s_axi_rvalid && s_axi_rresp == RESP_DEC |-> s_axi_rdata == 32'h0; endproperty
   property p_cap;
      s_axi_rvalid && s_axi_rresp == RESP_OKAY && ar_idx_q == IDX_CAP
         |-> s_axi_rdata[31:16] == 16'h0 && !s_axi_rdata[11];
   endproperty
   property p_ctl;
      s_axi_rvalid && s_axi_rresp == RESP_OKAY && ar_idx_q == IDX_CTRL
         |-> s_axi_rdata[31:16] == 16'h0 && !s_axi_rdata[9];
   endproperty
   a_force: assert property (p_force) else $error("force without gigabit select");
   a_gen: assert property (p_gen) else $error("generator LPI not on media");
   a_tx: assert property (p_tx) else $error("media LPI without MAC LPI");
   a_rx: assert property (p_rx) else $error("MAC LPI without media LPI");
   a_rlat: assert property (p_rlat) else $error("read data without request");
   a_bone: assert property (p_bone) else $error("write response held too long");
   a_dec: assert property (p_dec) else $error("refused read returned data");
   a_cap: assert property (p_cap) else $error("capability reserved bit set");
   a_ctl: assert property (p_ctl) else $error("control reserved bit set");
   // Main scenarios
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_dec: cover property (s_axi_rvalid && s_axi_rresp == RESP_DEC);
   c_force: cover property (force_1000_link);
endmodule

bind edc_regs edc_regs_checker edc_regs_checker_i (.*);

// file: tb/tb_edc_regs.sv
// Purpose: Self-checking bench for the Energy_efficiency_control and capability registers.
// Assumes: Master drives on rising edges and samples at falling edges.
// Notes:   Four of seven capability straps and the dash number differ from defaults to expose wiring slips.
module tb_edc_regs;
   timeunit 1ns;
   timeprecision 100ps;
   import edc_pkg::*;
   localparam int          LIMIT   = 5000;
   localparam logic [15:0] CAP_EXP = 16'hD227;
   localparam logic [7:0]  A_PG    = {IDX_PAGE, 2'h0};
   localparam logic [7:0]  A_CT    = {IDX_CTRL, 2'h0};
   localparam logic [7:0]  A_CP    = {IDX_CAP, 2'h0};
   logic        clk, rst, port_soft_rst, link_up, eee_1000_on, eee_100_on;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, led_state, led_out_n;
   logic [1:0]  s_axi_bresp, s_axi_rresp, link_speed, speed_sel;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, mac_tx_lpi, mdi_rx_lpi;
   logic        lp10_mode_en, led_fiber_uni_en, force_1000_link;
   logic        internal_packet_generator_lpi, mdi_tx_lpi, mac_rx_lpi;
   logic [15:0] page_sel;
   int          n_fail = 0;
   int          n_compared = 0;
   int          cyc = 0;
   // Dash number value is arbitrary
   edc_regs #(.IND_GRADE(1'b1), .PTP_CAP(1'b0), .DUAL_MED(1'b0), .KEY_256(1'b0),
      .DASH_BCD(8'h27)) edc_regs_i (.*);
   // Clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Verdict and end of run
   task automatic end_sim;
      if (n_fail == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One write; address and data released each as taken
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      logic pa, pw, ta, tw;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
         @(negedge clk);
         ta = pa && s_axi_awready;
         tw = pw && s_axi_wready;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge clk); while (s_axi_bvalid !== 1'b1);
      chk("bresp", 32'(er), 32'(s_axi_bresp));
      @(posedge clk);
      s_axi_bready <= 1'b0;
   endtask
   // One read; data and response compared
   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clk); while (s_axi_arready !== 1'b1);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk); while (s_axi_rvalid !== 1'b1);
      chk("rdata", {16'h0000, e}, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      @(posedge clk);
      s_axi_rready <= 1'b0;
   endtask
   // Let synchronisers and output flops catch up
   task automatic settle;
      repeat (6) @(negedge clk);
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_fail++;
         end_sim;
      end
   end
   // Main sequence
   initial begin
      {port_soft_rst, link_up, eee_1000_on, eee_100_on, mac_tx_lpi, mdi_rx_lpi} = '0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready, led_state, link_speed, speed_sel} = '0;
      s_axi_wstrb = 4'hF;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(A_PG, PAGE_MAIN, RESP_OKAY);
      rd(A_CT, 16'h0000, RESP_DEC);
      wr(A_PG, PAGE_TWO, RESP_OKAY);
      @(negedge clk);
      chk("page_sel", {16'h0000, PAGE_TWO}, {16'h0000, page_sel});
      rd(A_CT, CTRL_RST, RESP_OKAY);
      rd(A_CP, CAP_EXP, RESP_OKAY);
      wr(A_CP, 16'hFFFF, RESP_OKAY);
      rd(A_CP, CAP_EXP, RESP_OKAY);
      rd(8'h40, 16'h0000, RESP_DEC);
      wr(A_CT, 16'hFFFF, RESP_OKAY);
      rd(A_CT, CTRL_WMASK, RESP_OKAY);
      settle;
      chk("lp10_mode_en", 32'h1, 32'(lp10_mode_en));
      chk("led_fiber_uni_en", 32'h1, 32'(led_fiber_uni_en));
      chk("generator_lpi", 32'h1, 32'(internal_packet_generator_lpi));
      // Status bits follow the PHY core
      @(posedge clk);
      link_up <= 1'b1;
      eee_1000_on <= 1'b1;
      settle;
      rd(A_CT, CTRL_WMASK | 16'h0180, RESP_OKAY);
      @(posedge clk);
      {link_up, eee_1000_on, eee_100_on} <= 3'h1;
      settle;
      rd(A_CT, CTRL_WMASK | 16'h0040, RESP_OKAY);
      // LED polarity patterns
      @(posedge clk);
      {eee_100_on, led_state} <= 5'h03;
      for (int i = 0; i < 16; i += 5) begin
         wr(A_CT, 16'(i << B_INV_LO), RESP_OKAY);
         settle;
         chk("led_out_n", {28'h0, ~(4'h3 ^ 4'(i))}, {28'h0, led_out_n});
      end
      chk("lp10_mode_en", 32'h0, 32'(lp10_mode_en));
      // Forced gigabit only with the gigabit selection
      wr(A_CT, 16'h0020, RESP_OKAY);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         speed_sel <= 2'(s);
         settle;
         chk("force_1000_link", 32'(s == 2), 32'(force_1000_link));
      end
      // Each inhibit at both speeds, LPI arriving on both paths
      @(posedge clk);
      {mac_tx_lpi, mdi_rx_lpi} <= 2'h3;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         link_speed <= k[2] ? SPD_1000 : SPD_100;
         wr(A_CT, 16'(1 << k[1:0]), RESP_OKAY);
         settle;
         chk("mdi_tx_lpi", 32'(k[1:0] != (k[2] ? 2'h1 : 2'h3)), 32'(mdi_tx_lpi));
         chk("mac_rx_lpi", 32'(k[1:0] != (k[2] ? 2'h0 : 2'h2)), 32'(mac_rx_lpi));
      end
      // At 10 Mb/s no inhibit applies
      @(posedge clk);
      link_speed <= SPD_10;
      wr(A_CT, 16'h000F, RESP_OKAY);
      settle;
      chk("mdi_tx_lpi", 32'h1, 32'(mdi_tx_lpi));
      chk("mac_rx_lpi", 32'h1, 32'(mac_rx_lpi));
      // Generator LPI overrides the MAC; gigabit TX inhibit set but idle at 10 Mb/s
      @(posedge clk);
      mac_tx_lpi <= 1'b0;
      wr(A_CT, 16'h0012, RESP_OKAY);
      settle;
      chk("mdi_tx_lpi", 32'h1, 32'(mdi_tx_lpi));
      // Port soft reset clears paging, keeps sticky bits
      @(posedge clk);
      port_soft_rst <= 1'b1;
      @(posedge clk);
      port_soft_rst <= 1'b0;
      rd(A_PG, PAGE_MAIN, RESP_OKAY);
      @(negedge clk);
      chk("page_sel", {16'h0000, PAGE_MAIN}, {16'h0000, page_sel});
      rd(A_CT, 16'h0000, RESP_DEC);
      wr(A_PG, PAGE_TWO, RESP_OKAY);
      rd(A_CT, 16'h0012, RESP_OKAY);
      // Upper byte lane only
      @(posedge clk);
      s_axi_wstrb <= 4'h2;
      wr(A_CT, 16'hFFFF, RESP_OKAY);
      rd(A_CT, 16'hFC12, RESP_OKAY);
      @(posedge clk);
      s_axi_wstrb <= 4'hF;
      // Hardware reset restores defaults; debug bits back at default
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wr(A_PG, PAGE_TWO, RESP_OKAY);
      rd(A_CT, CTRL_RST, RESP_OKAY);
      end_sim;
   end
endmodule
